// [pattern_cfg_pkg.sv]
/*
 Package for the test-pattern / framing-clock configuration bank:
 register indices, field positions, reset values, codes and carriers.
 Assumes nothing of its surroundings.
*/
package pattern_cfg_pkg;

  // printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] idx_pattern_value_low            = 8'h14;
  localparam logic [7:0] idx_pattern_value_mid            = 8'h15;
  localparam logic [7:0] idx_pattern_select_and_value_top = 8'h16;
  localparam logic [7:0] idx_data_clock_input_enable      = 8'h18;
  localparam logic [7:0] idx_framing_clock_control        = 8'h19;
  localparam logic [7:0] idx_output_resolution_mapper     = 8'h1B;
  localparam logic [7:0] idx_companion_clock_enable       = 8'h1F;

  localparam logic [7:0] reg_reset = 8'h00;

  localparam int sel_lsb          = 2;
  localparam int top_value_lsb    = 0;
  localparam int data_clock_input_bit       = 4;
  localparam int companion_bit    = 6;
  localparam int framing_clock_origin_bit  = 7;
  localparam int framing_clock_halve_bit   = 4;
  localparam int framing_clock_pin_bit     = 1;
  localparam int mapper_on_bit    = 7;
  localparam int twenty_bit_bit   = 6;
  localparam int res_lsb          = 3;

  localparam int native_width = 18;

  typedef enum logic [2:0] {
    pat_normal   = 3'b000,
    pat_ramp     = 3'b010,
    pat_constant = 3'b011
  } pattern_mode_e;

  typedef enum logic [2:0] {
    res_18 = 3'b000,
    res_16 = 3'b001,
    res_14 = 3'b010
  } resolution_e;

  typedef struct packed {
    logic [17:0] pattern_value;
    logic [2:0]  pattern_select_chan_one;
    logic        data_clock_input_buffer_on;
    logic        framing_clock_origin;
    logic        framing_clock_halve;
    logic        framing_clock_pin_on;
    logic        mapper_on;
    logic        twenty_bit_output_on;
    logic [2:0]  remap_resolution_select;
  } cfg_s;

endpackage : pattern_cfg_pkg

// [pattern_source.sv]
/*
 Test-pattern source: replaces converter samples by a constant or a ramp
 word at native resolution, ahead of the output bit mapper.
 Assumes sample_valid marks one output sample per pulse.
*/
`timescale 1ns/1ps
module pattern_source #(
  parameter int width = 18
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [2:0]       mode,
  input  wire logic [width-1:0] value,
  input  wire logic             sample_valid,
  input  wire logic [width-1:0] sample_in,
  output logic      [width-1:0] word_out,
  output logic                  word_valid
);
  import pattern_cfg_pkg::*;

  logic [width-1:0] ramp;
  logic [width-1:0] next_ramp;

  always_comb begin
    next_ramp = ramp;
    if (mode == pat_ramp) begin
      next_ramp = ramp + value;
    end else begin
      next_ramp = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp <= '0;
    end else if (ce && (sample_valid || mode != pat_ramp)) begin
      ramp <= next_ramp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_out   <= '0;
      word_valid <= 1'b0;
    end else if (ce) begin
      word_valid <= sample_valid;
      if (sample_valid) begin
        unique case (mode)
          pat_ramp:     word_out <= ramp;
          pat_constant: word_out <= value;
          default:      word_out <= sample_in;
        endcase
      end
    end
  end

endmodule : pattern_source

// [pattern_frame_cfg.sv]
/*
 Configuration bank for the test-pattern generator and framing-clock
 control, reached over APB; drives the pattern source and exposes the
 framing-clock, buffer and mapper settings to the output path.
 Assumes a 32-bit APB master on pclk and 18-bit samples from the core.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module pattern_frame_cfg #(
  parameter int width = 18
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  input  wire logic               sample_valid,
  input  wire logic [width-1:0]   sample_in,
  output logic      [width-1:0]   mapper_in,
  output logic                    mapper_in_valid,
  output pattern_cfg_pkg::cfg_s   cfg,
  output logic                    data_clock_input_buffer_on,
  output logic                    framing_clock_from_ddc,
  output logic                    framing_clock_on_data_pin
);
  import pattern_cfg_pkg::*;

  logic [7:0] r14;
  logic [7:0] r15;
  logic [7:0] r16;
  logic [7:0] r18;
  logic [7:0] r19;
  logic [7:0] r1b;
  logic [7:0] r1f;

  logic       hit;
  logic [7:0] index;
  logic [7:0] rd_byte;
  logic       wr_go;

  // index is byte address over four; low bits must be zero
  assign index = paddr[9:2];
  // write lands at the edge where the master samples pready high
  assign wr_go = psel && penable && pwrite && ce && pready;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (index)
      idx_pattern_value_low:            rd_byte = r14;
      idx_pattern_value_mid:            rd_byte = r15;
      idx_pattern_select_and_value_top: rd_byte = r16;
      idx_data_clock_input_enable:      rd_byte = r18;
      idx_framing_clock_control:        rd_byte = r19;
      idx_output_resolution_mapper:     rd_byte = r1b;
      idx_companion_clock_enable:       rd_byte = r1f;
      default:                          hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // one wait state: pready is low in the first access cycle and high in the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // registers keep written value whole; must-write-0 bits are stored as is
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r14 <= reg_reset;
      r15 <= reg_reset;
      r16 <= reg_reset;
      r18 <= reg_reset;
      r19 <= reg_reset;
      r1b <= reg_reset;
      r1f <= reg_reset;
    end else if (wr_go && hit) begin
      unique case (index)
        idx_pattern_value_low:            r14 <= pwdata[7:0];
        idx_pattern_value_mid:            r15 <= pwdata[7:0];
        idx_pattern_select_and_value_top: r16 <= pwdata[7:0];
        idx_data_clock_input_enable:      r18 <= pwdata[7:0];
        idx_framing_clock_control:        r19 <= pwdata[7:0];
        idx_output_resolution_mapper:     r1b <= pwdata[7:0];
        idx_companion_clock_enable:       r1f <= pwdata[7:0];
        default:                          r14 <= r14;
      endcase
    end
  end

  logic [17:0] value;
  logic [2:0]  mode;
  assign value = {r16[top_value_lsb+:2], r15, r14};
  assign mode  = r16[sel_lsb+:3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg                        <= '0;
      data_clock_input_buffer_on <= 1'b0;
      framing_clock_from_ddc     <= 1'b0;
      framing_clock_on_data_pin  <= 1'b0;
    end else if (ce) begin
      cfg.pattern_value              <= value;
      cfg.pattern_select_chan_one    <= mode;
      cfg.data_clock_input_buffer_on <= r18[data_clock_input_bit];
      cfg.framing_clock_origin       <= r19[framing_clock_origin_bit];
      cfg.framing_clock_halve        <= r19[framing_clock_halve_bit];
      cfg.framing_clock_pin_on       <= r19[framing_clock_pin_bit];
      cfg.mapper_on                  <= r1b[mapper_on_bit];
      cfg.twenty_bit_output_on       <= r1b[twenty_bit_bit];
      cfg.remap_resolution_select    <= r1b[res_lsb+:3];
      data_clock_input_buffer_on <=
        r18[data_clock_input_bit] && r1f[companion_bit];
      framing_clock_from_ddc    <= r19[framing_clock_origin_bit];
      framing_clock_on_data_pin <= r19[framing_clock_pin_bit];
    end
  end

  // pattern inserted before the mapper, independent of output format
  pattern_source #(
    .width (width)
  ) u_source (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .mode         (mode),
    .value        (value[17-:width]),
    .sample_valid (sample_valid),
    .sample_in    (sample_in),
    .word_out     (mapper_in),
    .word_valid   (mapper_in_valid)
  );

endmodule : pattern_frame_cfg

// [pattern_frame_cfg_props.sv]
/* Checker for pattern_frame_cfg: APB answer and refusal, sample path.
 Assumes it is bound into every pattern_frame_cfg instance. */
`timescale 1ns/1ps
module pattern_frame_cfg_props
  import pattern_cfg_pkg::*;
#(
  parameter int width = 18
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  sample_valid,
  input wire logic [width-1:0]      sample_in,
  input wire logic [width-1:0]      mapper_in,
  input wire logic                  mapper_in_valid,
  input wire pattern_cfg_pkg::cfg_s cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic             mapped;
  logic             ramp_seen;
  logic [width-1:0] prev_word;
  cfg_s             last_cfg;
  assign mapped = paddr[1:0] == 2'h0 && paddr[11:2] inside
    {10'h014, 10'h015, 10'h016, 10'h018, 10'h019, 10'h01B, 10'h01F};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cfg <= '0;
    end else begin
      last_cfg <= cfg;
    end
  end
  // a left ramp restarts; a new step applies only from the second word after the change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_seen <= 1'b0;
      prev_word <= '0;
    end else if (cfg.pattern_select_chan_one != pat_ramp
                 || cfg != last_cfg) begin
      ramp_seen <= 1'b0;
    end else if (mapper_in_valid) begin
      ramp_seen <= 1'b1;
      prev_word <= mapper_in;
    end
  end
  a_wait_one: assert property (
    $rose(penable) && psel |-> !pready ##1 pready) else $error("no wait");
  a_pready_pulse: assert property (
    pready |=> !pready) else $error("pready too long");
  a_unmapped_err: assert property (
    pready |-> pslverr == !mapped) else $error("bad pslverr");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("prdata upper set");
  a_valid_next: assert property (
    ce && sample_valid |=> mapper_in_valid) else $error("no word");
  a_const_word: assert property (
    mapper_in_valid && cfg.pattern_select_chan_one == pat_constant
    && $stable(cfg) |-> mapper_in == cfg.pattern_value)
    else $error("bad constant");
  a_normal_pass: assert property (
    mapper_in_valid && cfg.pattern_select_chan_one == pat_normal
    && $stable(cfg) |-> mapper_in == $past(sample_in))
    else $error("bad pass");
  a_ramp_step: assert property (
    mapper_in_valid && ramp_seen && $stable(cfg)
    |-> mapper_in == prev_word + cfg.pattern_value) else $error("bad ramp");
  c_write: cover property (pready && pwrite && !pslverr);
  c_refused: cover property (pready && pslverr);
  c_ramp: cover property (mapper_in_valid && ramp_seen);
endmodule : pattern_frame_cfg_props

bind pattern_frame_cfg pattern_frame_cfg_props #(.width(width)) props_u (.*);

// [host_capture.sv]
/* Host capture model: keeps the latest output word and a count.
 Assumes word_valid is a one-cycle pulse per word. */
`timescale 1ns/1ps
module host_capture #(
  parameter int width = 18
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             word_valid,
  input  wire logic [width-1:0] word,
  output logic      [width-1:0] got,
  output int                    taken
);
  // word taken on its pulse only; the sender holds it until its next word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got <= '0;
      taken <= 0;
    end else if (word_valid) begin
      got <= word;
      taken <= taken + 1;
    end
  end
endmodule : host_capture

// [tb_pattern_frame_cfg.sv]
/* Bench for pattern_frame_cfg: APB register access, clock bits, patterns.
 Assumes the design answers APB with one wait state. */
`timescale 1ns/1ps
module tb_pattern_frame_cfg;
  import pattern_cfg_pkg::*;
  logic        pclk, pready, pslverr, mv, dbuf, fddc, fpin, err;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sv = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic [17:0] sin = 18'h0, mw, got, prev;
  cfg_s        cfg;
  int          fails, checks_done, seed, taken;
  logic [7:0]  idx [7] = '{8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1B, 8'h1F};
  logic [17:0] steps [4] = '{18'h1, 18'h4, 18'h10, 18'h3FFFF};
  pattern_frame_cfg dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_valid(sv), .sample_in(sin), .mapper_in(mw),
    .mapper_in_valid(mv), .cfg(cfg), .data_clock_input_buffer_on(dbuf),
    .framing_clock_from_ddc(fddc), .framing_clock_on_data_pin(fpin));
  host_capture host_u (.pclk(pclk), .presetn(presetn), .word_valid(mv),
    .word(mw), .got(got), .taken(taken));
  function automatic logic [17:0] ramp_exp(logic [17:0] p, logic [17:0] s);
    return p + s;
  endfunction : ramp_exp
  function automatic logic [11:0] ba(logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ba
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic smp(input logic [17:0] s);
    @(posedge pclk);
    sv <= 1'b1;
    sin <= s;
    @(posedge pclk);
    sv <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : smp
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #(25 * 20000);
    fails++;
    print_verdict();
  end
  initial begin
    seed = 49;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx[i]) begin
      apb(1'b0, ba(idx[i]), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h05C, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'h051, 32'hFF);
    apb(1'b0, 12'h050, 32'h0);
    chk(rd, 32'h0);
    foreach (idx[i]) begin
      v = $random(seed);
      apb(1'b1, ba(idx[i]), v);
      apb(1'b0, ba(idx[i]), 32'h0);
      chk(rd, {24'h0, v[7:0]});
    end
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & 32'h92;
      apb(1'b1, ba(8'h18), {27'h0, k[0], 4'h0});
      apb(1'b1, ba(8'h1F), {25'h0, k[1], 6'h0});
      apb(1'b1, ba(8'h19), v);
      repeat (3) @(posedge pclk);
      chk(dbuf, k[0] & k[1]);
      chk(fddc, v[7]);
      chk(fpin, v[1]);
      chk(cfg.framing_clock_halve, v[4]);
      chk(cfg.framing_clock_origin, v[7]);
    end
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      apb(1'b1, ba(8'h19), {30'h0, k[0], 1'b0});
      apb(1'b1, ba(8'h14), {24'h0, v[7:0]});
      apb(1'b1, ba(8'h15), {24'h0, v[15:8]});
      apb(1'b1, ba(8'h16), {27'h0, pat_constant, v[17:16]});
      smp(v[31:14]);
      chk(got, v[17:0]);
    end
    foreach (steps[j]) begin
      apb(1'b1, ba(8'h14), {24'h0, steps[j][7:0]});
      apb(1'b1, ba(8'h15), {24'h0, steps[j][15:8]});
      apb(1'b1, ba(8'h16), {27'h0, pat_ramp, steps[j][17:16]});
      smp(18'h0);
      prev = got;
      repeat (3) begin
        v = $random(seed);
        smp(v[17:0]);
        chk(got, ramp_exp(prev, steps[j]));
        prev = got;
      end
    end
    $display("pattern test done");
    for (int c = 0; c < 8; c++) begin
      if (c == 2 || c == 3) continue;
      apb(1'b1, ba(8'h16), {27'h0, c[2:0], 2'h0});
      v = $random(seed);
      smp(v[17:0]);
      chk(got, v[17:0]);
    end
    $display("normal test done");
    print_verdict();
  end
endmodule : tb_pattern_frame_cfg
